/* pkg/lsos_pkg.sv */
// constants, field layouts and states of the line supply sequencer
// assumes one 125 MHz system clock shared by every user of this package
package lsos_pkg;

   // ------------------------------------------------------------
   // clock and switch-off delay time base
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int DELAY_UNIT_NS = 1000000; // delay counts milliseconds
   localparam int DELAY_UNIT_CYCLES = (DELAY_UNIT_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // supply_control_word bit positions
   // ------------------------------------------------------------
   localparam int CW_ON_OFF = 0;
   localparam int CW_NO_COAST = 1;
   localparam int CW_ENABLE_OP = 3;
   localparam int CW_INHIBIT_REGEN = 6;
   localparam int CW_ACK = 7;
   localparam int CW_PLC = 10;

   // ------------------------------------------------------------
   // supply_status_word bit positions and reset value
   // ------------------------------------------------------------
   localparam int SW_READY_ON = 0;
   localparam int SW_READY_RUN = 1;
   localparam int SW_OP_ENABLED = 2;
   localparam int SW_FAULT = 3;
   localparam int SW_NO_COAST = 4;
   localparam int SW_ON_DISABLED = 6;
   localparam int SW_ALARM = 7;
   localparam int SW_PLC = 9;
   localparam int SW_PRECHARGED = 11;
   localparam int SW_CONTACTOR = 12;
   localparam logic [15:0] SW_RESET = 16'h0040;
   localparam logic [15:0] CW_RESET = 16'h0000;

   // ------------------------------------------------------------
   // signal interconnection source codes
   // ------------------------------------------------------------
   localparam logic [1:0] SRC_LOW = 2'h0;
   localparam logic [1:0] SRC_HIGH = 2'h1;
   localparam logic [1:0] SRC_TERM = 2'h2;
   localparam logic [1:0] SRC_BUS = 2'h3;

   // ------------------------------------------------------------
   // terminal input vector positions
   // ------------------------------------------------------------
   localparam int TERM_WIDTH = 15;
   localparam int T_ON_OFF = 0;
   localparam int T_COAST_ONE = 1;
   localparam int T_COAST_TWO = 2;
   localparam int T_ENABLE_OP = 3;
   localparam int T_INHIBIT = 4;
   localparam int T_ACK_ONE = 5;
   localparam int T_ACK_TWO = 6;
   localparam int T_ACK_THREE = 7;
   localparam int T_PLC = 8;
   localparam int T_PULSE_EN = 9;
   localparam int T_PRECHARGED = 10;
   localparam int T_CONTACTOR = 11;
   localparam int T_FAULT = 12;
   localparam int T_ALARM = 13;
   localparam int T_SPARE = 14;

   // ------------------------------------------------------------
   // operating display codes and missing enable map bits
   // ------------------------------------------------------------
   localparam logic [7:0] DISP_WAIT_ENABLE = 8'h00;
   localparam logic [7:0] DISP_RUN = 8'h01;
   localparam logic [7:0] DISP_OFF_DELAY = 8'h02;
   localparam logic [7:0] DISP_ON_DISABLED = 8'h03;
   localparam logic [7:0] DISP_FAULT = 8'h04;
   localparam logic [7:0] MISS_RESET = 8'h00;
   localparam int MISS_ON_OFF = 0;
   localparam int MISS_COAST = 1;
   localparam int MISS_PULSE_EN = 2;
   localparam int MISS_ENABLE_OP = 3;
   localparam int MISS_PRECHARGE = 4;
   localparam int MISS_CONTACTOR = 5;

   // ------------------------------------------------------------
   // sequencer states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_DISABLED = 3'b000,
      ST_READY_ON = 3'b001,
      ST_PRECHARGE = 3'b010,
      ST_READY_RUN = 3'b011,
      ST_RUN = 3'b100,
      ST_OFF_DELAY = 3'b101,
      ST_FAULT = 3'b110
   } lsos_state_type;

endpackage

/* logic/lsos_sync2.sv */
// two flip-flop synchroniser for a vector of independent levels
// assumes each bit is a slow level from a pin, not a bus of related bits
`timescale 1ns/10ps
`default_nettype none
module lsos_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // first stage is read by the second stage only
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule
`default_nettype wire

/* logic/lsos_sequencer.sv */
// on/off sequencer of an unregulated line supply, both variants
// assumes terminal pins are asynchronous and bus word is on clk_sys_i
`timescale 1ns/10ps
`default_nettype none
module lsos_sequencer
   import lsos_pkg::*;
#(
   parameter bit REGEN = 1'b1,
   parameter int TICK_CYCLES = lsos_pkg::DELAY_UNIT_CYCLES
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic [lsos_pkg::TERM_WIDTH-1:0] term_pins_i,
   input wire logic [15:0] bus_control_word_i,
   input wire logic bus_telegram_active_i,
   input wire logic [1:0] on_off_source_i,
   input wire logic [1:0] coast_stop_source_one_i,
   input wire logic [1:0] coast_stop_source_two_i,
   input wire logic [1:0] enable_operation_source_i,
   input wire logic [1:0] inhibit_regen_source_i,
   input wire logic [1:0] ack_source_one_i,
   input wire logic [1:0] ack_source_two_i,
   input wire logic [1:0] ack_source_three_i,
   input wire logic [1:0] plc_control_source_i,
   input wire logic [15:0] switch_off_delay_time_i,
   output logic [15:0] supply_control_word_o,
   output logic [15:0] supply_status_word_o,
   output logic [7:0] operating_display_o,
   output logic [7:0] missing_enable_map_o,
   output logic pulses_enabled_o
);
   import lsos_pkg::*;

   // every assertion below samples on the system clock, off in reset
   default clocking cb_sys @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
   if (TICK_CYCLES < 1) begin : g_bad_tick
      $error("TICK_CYCLES must be at least one");
   end

   logic [TERM_WIDTH-1:0] term;
   logic [15:0] bus_w;
   lsos_state_type state_q, state_d;
   logic [15:0] ctl_q, status_q, delay_q;
   logic [TW-1:0] tick_q;
   logic [7:0] disp_q, miss_q;
   logic on_prev_q, ack_prev_q, pulses_q;

   // ------------------------------------------------------------
   // pin synchronisation and source selection
   // ------------------------------------------------------------
   lsos_sync2 #(.WIDTH(TERM_WIDTH)) u_sync (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .async_i(term_pins_i),
      .sync_o(term)
   );

   // bus bits count only while a telegram is active
   assign bus_w = bus_telegram_active_i ? bus_control_word_i : 16'h0000;

   function automatic logic pick(input logic [1:0] sel, input logic t,
                                 input logic b);
      case (sel)
         SRC_LOW: pick = 1'b0;
         SRC_HIGH: pick = 1'b1;
         SRC_TERM: pick = t;
         default: pick = b;
      endcase
   endfunction

   // interconnection of every command to its source
   wire logic on_cmd = pick(on_off_source_i, term[T_ON_OFF],
                            bus_w[CW_ON_OFF]);
   // both coast sources must be high for no coast stop
   wire logic no_coast = pick(coast_stop_source_one_i, term[T_COAST_ONE],
                              bus_w[CW_NO_COAST])
                         & pick(coast_stop_source_two_i, term[T_COAST_TWO],
                                bus_w[CW_NO_COAST]);
   // any of three ack sources acknowledges
   wire logic ack_cmd = pick(ack_source_one_i, term[T_ACK_ONE],
                             bus_w[CW_ACK])
                        | pick(ack_source_two_i, term[T_ACK_TWO],
                               bus_w[CW_ACK])
                        | pick(ack_source_three_i, term[T_ACK_THREE],
                               bus_w[CW_ACK]);
   // basic variant has no enable-op or inhibit bits
   wire logic en_op = REGEN ? pick(enable_operation_source_i,
                                   term[T_ENABLE_OP],
                                   bus_w[CW_ENABLE_OP]) : 1'b1;
   wire logic inhibit = REGEN ? pick(inhibit_regen_source_i, term[T_INHIBIT],
                                     bus_w[CW_INHIBIT_REGEN]) : 1'b0;
   wire logic plc = pick(plc_control_source_i, term[T_PLC], bus_w[CW_PLC]);
   wire logic pulse_en = term[T_PULSE_EN];
   wire logic fault_cause = term[T_FAULT];
   wire logic on_rise = on_cmd & ~on_prev_q;
   wire logic ack_rise = ack_cmd & ~ack_prev_q;
   wire logic delay_done = (delay_q == 16'h0000);
   wire logic tick = (tick_q == TICK_LAST);

   // control word image, regen layout or basic layout
   wire logic [15:0] ctl_d = {5'h00, plc, 2'h0, ack_cmd,
                              REGEN ? inhibit : 1'b0, 2'h0,
                              REGEN ? en_op : 1'b0, 1'b0, no_coast, on_cmd};

   // ------------------------------------------------------------
   // sequence state machine
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_DISABLED: if (~on_cmd && no_coast) state_d = ST_READY_ON;
         // power up needs pulse enable then on edge
         ST_READY_ON: begin
            if (!no_coast) state_d = ST_DISABLED;
            else if (pulse_en && on_rise) state_d = ST_PRECHARGE;
         end
         ST_PRECHARGE: begin
            if (!no_coast || !on_cmd || !pulse_en) state_d = ST_DISABLED;
            else if (term[T_PRECHARGED] && term[T_CONTACTOR])
               state_d = ST_READY_RUN;
         end
         ST_READY_RUN: begin
            if (!no_coast || !on_cmd || !pulse_en) state_d = ST_DISABLED;
            else if (en_op) state_d = ST_RUN;
         end
         // dropping on starts the switch-off delay
         ST_RUN: begin
            if (!no_coast || !pulse_en) state_d = ST_DISABLED;
            else if (!on_cmd) state_d = ST_OFF_DELAY;
            else if (!en_op) state_d = ST_READY_RUN;
         end
         ST_OFF_DELAY: begin
            if (!no_coast || !pulse_en) state_d = ST_DISABLED;
            else if (on_cmd) state_d = ST_RUN;
            else if (delay_done) state_d = ST_READY_ON;
         end
         // held ack level does nothing, only its edge
         ST_FAULT: if (ack_rise && !fault_cause) state_d = ST_DISABLED;
         default: state_d = ST_DISABLED;
      endcase
      if (fault_cause && REGEN) state_d = ST_FAULT;
   end

   // ------------------------------------------------------------
   // status, display and missing enables
   // ------------------------------------------------------------
   wire logic s_ready_on = (state_q != ST_DISABLED) && (state_q != ST_FAULT);
   wire logic s_ready_run = (state_q == ST_READY_RUN) || (state_q == ST_RUN)
                            || (state_q == ST_OFF_DELAY);
   wire logic s_running = (state_q == ST_RUN) || (state_q == ST_OFF_DELAY);
   wire logic s_fault = (state_q == ST_FAULT);
   // status bits by position, fault and alarm regen only
   wire logic [15:0] status_d = {3'h0, term[T_CONTACTOR], term[T_PRECHARGED],
                                 1'b0, plc, 1'b0, REGEN & term[T_ALARM],
                                 ~s_ready_on, 1'b0, no_coast,
                                 REGEN & s_fault, s_running, s_ready_run,
                                 s_ready_on};
   wire logic [7:0] disp_d = s_fault ? DISP_FAULT :
                             (state_q == ST_DISABLED) ? DISP_ON_DISABLED :
                             (state_q == ST_OFF_DELAY) ? DISP_OFF_DELAY :
                             (state_q == ST_RUN) ? DISP_RUN :
                             DISP_WAIT_ENABLE;
   wire logic [7:0] miss_all = {2'h0, ~term[T_CONTACTOR], ~term[T_PRECHARGED],
                                ~en_op, ~pulse_en, ~no_coast, ~on_cmd};
   // map valid only while waiting for enables
   wire logic [7:0] miss_d = (disp_d == DISP_WAIT_ENABLE) ? miss_all
                                                          : MISS_RESET;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // state, edge history and every status bit each cycle
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         state_q <= ST_DISABLED;
         on_prev_q <= 1'b0;
         ack_prev_q <= 1'b0;
         ctl_q <= CW_RESET;
         status_q <= SW_RESET;
         disp_q <= DISP_ON_DISABLED;
         miss_q <= MISS_RESET;
         pulses_q <= 1'b0;
      end else begin
         state_q <= state_d;
         on_prev_q <= on_cmd;
         ack_prev_q <= ack_cmd;
         ctl_q <= ctl_d;
         status_q <= status_d;
         disp_q <= disp_d;
         miss_q <= miss_d;
         pulses_q <= (state_d == ST_RUN) || (state_d == ST_OFF_DELAY);
      end
   end

   // switch-off delay in units of TICK_CYCLES
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || state_q != ST_OFF_DELAY) begin
         tick_q <= '0;
         delay_q <= switch_off_delay_time_i;
      end else if (tick) begin
         tick_q <= '0;
         delay_q <= delay_done ? delay_q : delay_q - 16'h0001;
      end else begin
         tick_q <= tick_q + TW'(1);
      end
   end

   assign supply_control_word_o = ctl_q;
   assign supply_status_word_o = status_q;
   assign operating_display_o = disp_q;
   assign missing_enable_map_o = miss_q;
   assign pulses_enabled_o = pulses_q;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_power_up_edge: assert property (
      (state_q == ST_READY_ON && state_d == ST_PRECHARGE)
      |-> (pulse_en && on_cmd && !$past(on_cmd)))
      else $error("power up without pulse enable and on edge");
   a_ack_level_held: assert property (
      (state_q == ST_FAULT && $past(ack_cmd) && ack_cmd) |=> s_fault || !REGEN)
      else $error("held acknowledge left fault state");
   a_ack_clears: assert property (
      (s_fault && ack_rise && !fault_cause) |=> state_q == ST_DISABLED)
      else $error("acknowledge edge did not clear fault");
   a_off_delay_held: assert property (
      (state_q == ST_RUN && state_d == ST_OFF_DELAY && on_cmd == 1'b0
       && switch_off_delay_time_i != 16'h0000 && TICK_CYCLES > 1)
      |=> s_running [*2])
      else $error("switch-off not delayed");
   a_status_follows: assert property (
      ##1 supply_status_word_o[SW_OP_ENABLED] == $past(s_running)
      && supply_status_word_o[SW_ON_DISABLED] == $past(~s_ready_on))
      else $error("status word not tracking state");
   a_basic_status: assert property (
      !REGEN |-> !supply_status_word_o[SW_FAULT]
      && !supply_status_word_o[SW_ALARM])
      else $error("basic variant reports fault or alarm");
   a_basic_control: assert property (
      !REGEN |-> !supply_control_word_o[CW_ENABLE_OP]
      && !supply_control_word_o[CW_INHIBIT_REGEN])
      else $error("basic variant shows regen-only control bits");
   a_control_layout: assert property (
      ##1 supply_control_word_o[CW_ON_OFF] == $past(on_cmd)
      && supply_control_word_o[CW_ACK] == $past(ack_cmd))
      else $error("control word bits misplaced");
   a_missing_map: assert property (
      operating_display_o != DISP_WAIT_ENABLE
      |-> missing_enable_map_o == 8'h00)
      else $error("missing map shown outside display 00");
   a_coast_stop: assert property (
      (!no_coast && !fault_cause) |=> state_q == ST_DISABLED)
      else $error("coast stop did not disable");
   a_bus_masked: assert property (
      (!bus_telegram_active_i && on_off_source_i == SRC_BUS) |-> !on_cmd)
      else $error("bus on command used without telegram");
   a_regen_fault: assert property (
      (REGEN && fault_cause) |=> ##1 supply_status_word_o[SW_FAULT])
      else $error("fault not reported in status bit 3");
endmodule
`default_nettype wire

/* verification/lsos_plc_model.sv */
// plc model driving the terminal pins and the field-bus control word
// assumes the bench calls its tasks from one process only
`timescale 1ns/10ps
`default_nettype none
module lsos_plc_model
   import lsos_pkg::*;
(
   input wire logic clk_sys_i,
   output logic [lsos_pkg::TERM_WIDTH-1:0] term_pins_o,
   output logic [15:0] bus_control_word_o,
   output logic bus_telegram_active_o
);
   // idle wiring: all terminals open, no telegram
   initial begin
      term_pins_o = 15'h0000;
      bus_control_word_o = 16'h0000;
      bus_telegram_active_o = 1'b0;
   end
   // one pin change, launched just after a rising edge
   task automatic pin(input int idx, input logic val);
      @(posedge clk_sys_i);
      #1;
      term_pins_o[idx] = val;
   endtask
   // new telegram contents, same launch point
   task automatic bus(input logic [15:0] word, input logic act);
      @(posedge clk_sys_i);
      #1;
      bus_control_word_o = word;
      bus_telegram_active_o = act;
   endtask
   // pulse enable first, then on command edge from low
   task automatic power_up();
      pin(T_ON_OFF, 1'b0);
      pin(T_PULSE_EN, 1'b1);
      repeat (6) @(posedge clk_sys_i);
      pin(T_ON_OFF, 1'b1);
   endtask
endmodule
`default_nettype wire

/* verification/lsos_sequencer_tb_top.sv */
// self-checking bench for both variants of the line supply sequencer
// assumes the plc model owns the pins; bench owns sources and reset
`timescale 1ns/10ps
`default_nettype none
module lsos_sequencer_tb_top;
   import lsos_pkg::*;
   localparam int TICK = 4;
   localparam int DLY = 3;
   logic clk_sys, sys_rst;
   logic [1:0] s_on, s_c1, s_c2, s_en, s_inh, s_a1, s_a2, s_a3, s_plc;
   logic [15:0] dly_time;
   wire logic [14:0] pins;
   wire logic [15:0] bus_w;
   wire logic bus_act;
   logic [15:0] cw_r, sw_r, cw_b, sw_b;
   logic [7:0] disp_r, map_r, disp_b, map_b;
   logic pul_r, pul_b;
   int fail_count, samples_checked, n;
   // ------------------------------------------------------------
   // instances: regenerative and basic variant share every input
   // ------------------------------------------------------------
   lsos_plc_model i_lsos_plc_model (.clk_sys_i(clk_sys),
      .term_pins_o(pins), .bus_control_word_o(bus_w),
      .bus_telegram_active_o(bus_act));
   lsos_sequencer #(.REGEN(1'b1), .TICK_CYCLES(TICK)) i_lsos_sequencer (
      .clk_sys_i(clk_sys), .sys_rst_i(sys_rst), .term_pins_i(pins),
      .bus_control_word_i(bus_w), .bus_telegram_active_i(bus_act),
      .on_off_source_i(s_on), .coast_stop_source_one_i(s_c1),
      .coast_stop_source_two_i(s_c2), .enable_operation_source_i(s_en),
      .inhibit_regen_source_i(s_inh), .ack_source_one_i(s_a1),
      .ack_source_two_i(s_a2), .ack_source_three_i(s_a3),
      .plc_control_source_i(s_plc), .switch_off_delay_time_i(dly_time),
      .supply_control_word_o(cw_r), .supply_status_word_o(sw_r),
      .operating_display_o(disp_r), .missing_enable_map_o(map_r),
      .pulses_enabled_o(pul_r));
   lsos_sequencer #(.REGEN(1'b0), .TICK_CYCLES(TICK)) i_lsos_sequencer_basic (
      .clk_sys_i(clk_sys), .sys_rst_i(sys_rst), .term_pins_i(pins),
      .bus_control_word_i(bus_w), .bus_telegram_active_i(bus_act),
      .on_off_source_i(s_on), .coast_stop_source_one_i(s_c1),
      .coast_stop_source_two_i(s_c2), .enable_operation_source_i(s_en),
      .inhibit_regen_source_i(s_inh), .ack_source_one_i(s_a1),
      .ack_source_two_i(s_a2), .ack_source_three_i(s_a3),
      .plc_control_source_i(s_plc), .switch_off_delay_time_i(dly_time),
      .supply_control_word_o(cw_b), .supply_status_word_o(sw_b),
      .operating_display_o(disp_b), .missing_enable_map_o(map_b),
      .pulses_enabled_o(pul_b));
   // 125 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // ------------------------------------------------------------
   // compare, wait and closing tasks
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // bounded wait for a status bit of the regenerative variant
   task automatic wait_sw(input int b, input logic v);
      for (n = 0; n < 300 && sw_r[b] !== v; n++) begin
         @(posedge clk_sys);
         #1;
      end
      if (sw_r[b] !== v) begin
         fail_count++;
         $display("wait expired at %0t on status bit %0d", $time, b);
         tally_and_finish();
      end
   endtask
   task automatic wait_disp(input logic [7:0] code);
      for (n = 0; n < 300 && disp_r !== code; n++) begin
         @(posedge clk_sys);
         #1;
      end
      check({8'h00, disp_r}, {8'h00, code});
      if (disp_r !== code) tally_and_finish();
   endtask
   task automatic settle();
      repeat (6) @(posedge clk_sys);
      #1;
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      fail_count = 0;
      samples_checked = 0;
      sys_rst = 1'b1;
      {s_c1, s_c2, s_en, s_plc} = {SRC_HIGH, SRC_HIGH, SRC_HIGH, SRC_HIGH};
      {s_on, s_a1, s_a2, s_a3} = {SRC_TERM, SRC_TERM, SRC_TERM, SRC_TERM};
      s_inh = SRC_LOW;
      dly_time = 16'h0003;
      repeat (6) @(posedge clk_sys);
      #1;
      check(sw_r, SW_RESET);
      check({cw_r[7:0], disp_r}, {8'h00, DISP_ON_DISABLED});
      check({map_r, 7'h00, pul_r}, 16'h0000);
      sys_rst = 1'b0;
      $display("test reset done");
      // bus image: all ones gives only the documented bits
      {s_on, s_c1, s_c2, s_en, s_inh} = {5{SRC_BUS}};
      {s_a1, s_a2, s_a3, s_plc} = {4{SRC_BUS}};
      i_lsos_plc_model.bus(16'hffff, 1'b1);
      settle();
      check(cw_r, 16'h04cb);
      check(cw_b, 16'h0483);
      i_lsos_plc_model.bus(16'hffff, 1'b0);
      settle();
      check(cw_r, 16'h0000);
      // each source code for on/off, terminal high and bus bit low
      i_lsos_plc_model.bus(16'h0000, 1'b1);
      i_lsos_plc_model.pin(T_ON_OFF, 1'b1);
      for (int k = 0; k < 4; k++) begin
         s_on = k[1:0];
         settle();
         check({15'h0000, cw_r[0]}, {15'h0000, k == 1 || k == 2});
      end
      $display("test control image done");
      {s_c1, s_c2, s_en, s_plc} = {SRC_HIGH, SRC_HIGH, SRC_HIGH, SRC_HIGH};
      {s_on, s_a1, s_a2, s_a3} = {SRC_TERM, SRC_TERM, SRC_TERM, SRC_TERM};
      s_inh = SRC_LOW;
      // power up, enables missing while precharge pending
      i_lsos_plc_model.bus(16'h0000, 1'b0);
      wait_sw(SW_READY_ON, 1'b0);
      i_lsos_plc_model.power_up();
      wait_disp(DISP_WAIT_ENABLE);
      check({8'h00, map_r & 8'h30}, 16'h0030);
      i_lsos_plc_model.pin(T_PRECHARGED, 1'b1);
      i_lsos_plc_model.pin(T_CONTACTOR, 1'b1);
      wait_sw(SW_OP_ENABLED, 1'b1);
      #1;
      check(sw_r, 16'h1a17);
      check(sw_b, 16'h1a17);
      check({disp_r, 7'h00, pul_r}, {DISP_RUN, 8'h01});
      // alarm shown only by the regenerative variant
      i_lsos_plc_model.pin(T_ALARM, 1'b1);
      settle();
      check({sw_r[7], sw_b[7]}, 16'h0002);
      i_lsos_plc_model.pin(T_ALARM, 1'b0);
      $display("test power up done");
      // off command: delay of DLY ticks with pulses still on
      i_lsos_plc_model.pin(T_ON_OFF, 1'b0);
      wait_disp(DISP_OFF_DELAY);
      check({15'h0000, pul_r}, 16'h0001);
      for (n = 0; n < 300 && disp_r === DISP_OFF_DELAY; n++) begin
         @(posedge clk_sys);
         #1;
      end
      check({15'h0, n >= DLY * TICK && n <= DLY * TICK + 4}, 16'h1);
      if (n >= 300) tally_and_finish();
      i_lsos_plc_model.pin(T_PULSE_EN, 1'b0);
      $display("test switch off done");
      // faults: held ack ignored, each ack source clears on an edge
      for (int a = 0; a < 3; a++) begin
         i_lsos_plc_model.pin(T_ACK_ONE + a, 1'b1);
         i_lsos_plc_model.pin(T_FAULT, 1'b1);
         wait_sw(SW_FAULT, 1'b1);
         i_lsos_plc_model.pin(T_FAULT, 1'b0);
         settle();
         check({sw_r[SW_FAULT], sw_b[SW_FAULT]}, 16'h0002);
         check({8'h00, disp_r}, {8'h00, DISP_FAULT});
         i_lsos_plc_model.pin(T_ACK_ONE + a, 1'b0);
         settle();
         i_lsos_plc_model.pin(T_ACK_ONE + a, 1'b1);
         wait_sw(SW_FAULT, 1'b0);
         check({15'h0000, sw_r[SW_FAULT]}, 16'h0000);
         i_lsos_plc_model.pin(T_ACK_ONE + a, 1'b0);
      end
      $display("test acknowledge done");
      // coast stop formed from both sources, second one dropped
      s_c2 = SRC_LOW;
      settle();
      check({cw_r[1], sw_r[SW_NO_COAST]}, 16'h0000);
      s_c2 = SRC_HIGH;
      settle();
      check({cw_r[1], sw_r[SW_NO_COAST]}, 16'h0003);
      $display("test coast stop done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
